// >>> hw/vdc_defines.svh
// Constants for the vehicle detector conditioning block
`ifndef VDC_DEFINES_SVH
`define VDC_DEFINES_SVH
`define VDC_N_DET 128
`define VDC_N_PHASE 16
`define VDC_CLK_NS 20
`define VDC_TICK_NS 100000000
`define VDC_TENTHS_PER_SEC 12'h00a
`define VDC_TENTHS_PER_MIN 18'h00258
`define VDC_TICKS_PER_MIN 10'h257
`define VDC_CODE_NONE 8'h00
`define VDC_CODE_STUCK 8'hd2
`define VDC_CODE_IDLE 8'hd3
`define VDC_CODE_CHATTER 8'hd9
`define VDC_HOLD_OFF 8'h00
`define VDC_HOLD_CONST 8'hff
`endif

// >>> hw/vdc_pkg.sv
// Types shared by the vehicle detector conditioning block
package vdc_pkg;
  typedef struct packed {
    logic [4:0] call_phase;
    logic [4:0] switch_phase;
    logic [11:0] delay_tenths;
    logic [7:0] extend_tenths;
    logic [7:0] queue_sec;
    logic [7:0] idle_timeout;
    logic [7:0] stuck_on_timeout;
    logic [7:0] chatter_threshold;
    logic [7:0] failure_hold_time;
    logic opt_call;
    logic opt_extend;
    logic opt_queue;
    logic [7:0] src_sel;
  } vdc_cfg_t;

  typedef struct packed {
    logic [15:0] green;
    logic [15:0] yellow;
  } vdc_phase_t;

  typedef logic [15:0][7:0] vdc_sec_arr_t;

  typedef enum logic {SCAN_IDLE, SCAN_RUN} vdc_scan_t;
endpackage

// >>> hw/vdc_core.sv
// Per-detector call, extend and diagnostic conditioning for 128 detectors
`include "vdc_defines.svh"

// Function
// R1: Delay actuations while primary phase not green
// R2: Stretch green actuations by extend time
// R3: Queue timer from green start cuts actuations
// R4: Queue only with queue on, extend off
// R5: Forward on red with call, green with extend/queue
// R6: Phase zero suppresses call and extend
// R7: Primary red/yellow, secondary green: extend secondary
// R8: Call when primary and secondary not green
// R9: Green actuation with extend resets extension
// R10: Idle timeout fails detector, call clears
// R11: Idle failure reports code 211
// R12: Stuck-on timeout fails detector until call drops
// R13: Stuck-on failure reports code 210
// R14: Chatter above threshold per minute fails detector
// R15: Chatter failure reports code 217
// R16: Failure recalls phase, longer of min/hold
// R17: Hold time zero disables failure recall
// R18: Hold time 255 gives constant extend
// R19: Failure service capped at maximum green
// R20: Idle and stuck timeouts counted in minutes
// R21: 128 detectors, sourced physical or logical
// R22: Separate state, all evaluated each tick
module vdc_core #(
  parameter int N_DET = `VDC_N_DET,
  parameter int TICK_CYCLES = `VDC_TICK_NS / `VDC_CLK_NS
) (
  input wire logic clk,                  // 50 MHz clock
  input wire logic resetn,               // Synchronous reset
  input wire logic cfg_we,               // Configuration write strobe
  input wire logic [6:0] cfg_idx,        // Detector being configured
  input wire vdc_pkg::vdc_cfg_t cfg_data, // Configuration word
  input wire vdc_pkg::vdc_phase_t phase, // Phase green and yellow
  input wire vdc_pkg::vdc_sec_arr_t min_green, // Min green per phase
  input wire vdc_pkg::vdc_sec_arr_t max_green, // Max green per phase
  input wire logic [N_DET-1:0] det_in,   // Physical presence inputs
  input wire logic [6:0] occ_sel,        // Detector for fault code
  output logic [N_DET-1:0] call_out,     // Call on primary phase
  output logic [N_DET-1:0] ext_out,      // Extend primary phase
  output logic [N_DET-1:0] sec_ext_out,  // Extend secondary phase
  output logic [N_DET-1:0] fail_out,     // Any diagnostic failure
  output logic [7:0] occ_code,           // Occupancy fault code
  output logic scan_busy                 // Tick evaluation running
);
  localparam int TW = $clog2(TICK_CYCLES + 1);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic phase_on(input logic [15:0] v,
                                    input logic [4:0] p);
    phase_on = (p != 5'h00) && (p <= 5'h10) && v[4'(p - 5'h01)];
  endfunction

  function automatic logic [11:0] sec_to_tenths(input logic [7:0] s);
    sec_to_tenths = 12'(s) * `VDC_TENTHS_PER_SEC;
  endfunction

  function automatic logic [17:0] min_to_tenths(input logic [7:0] m);
    min_to_tenths = 18'(m) * `VDC_TENTHS_PER_MIN;
  endfunction

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  vdc_pkg::vdc_cfg_t cfg_mem [N_DET];
  logic [11:0] dly_cnt [N_DET];
  logic [7:0] ext_cnt [N_DET];
  logic [11:0] q_cnt [N_DET];
  logic [17:0] idle_cnt [N_DET];
  logic [17:0] stuck_cnt [N_DET];
  logic [7:0] chat_cnt [N_DET];
  logic [11:0] hold_cnt [N_DET];
  logic [N_DET-1:0] prev_pres;
  logic [N_DET-1:0] pres_q;
  logic [N_DET-1:0] idle_f;
  logic [N_DET-1:0] stuck_f;
  logic [N_DET-1:0] chat_f;

  logic [TW-1:0] tick_cnt;
  logic tick;
  logic [9:0] min_cnt;
  logic minute_end;
  vdc_pkg::vdc_scan_t scan_state;
  logic [6:0] idx;
  logic scan_v;
  logic [6:0] last_d;

  // ---------------------------------------------------------------
  // Tenth-second time base
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end
    else if (tick_cnt == TW'(TICK_CYCLES - 1))
    begin
      tick_cnt <= '0;
      tick <= 1'b1;
    end
    else
    begin
      tick_cnt <= tick_cnt + TW'(1);
      tick <= 1'b0;
    end
  end

  // Minute boundary for counts per minute
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      min_cnt <= 10'h000;
      minute_end <= 1'b0;
    end
    else if (tick)
    begin
      minute_end <= (min_cnt == `VDC_TICKS_PER_MIN);
      min_cnt <= (min_cnt == `VDC_TICKS_PER_MIN) ? 10'h000
                                                 : min_cnt + 10'h001;
    end
  end

  // ---------------------------------------------------------------
  // Scan sequencer
  // ---------------------------------------------------------------
  // R22: every detector visited once per tick
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      scan_state <= vdc_pkg::SCAN_IDLE;
      idx <= 7'h00;
      scan_busy <= 1'b0;
      last_d <= 7'h00;
    end
    else
    begin
      last_d <= idx;
      case (scan_state)
        vdc_pkg::SCAN_IDLE:
        begin
          idx <= 7'h00;
          if (tick)
          begin
            scan_state <= vdc_pkg::SCAN_RUN;
            scan_busy <= 1'b1;
          end
        end
        vdc_pkg::SCAN_RUN:
        begin
          idx <= idx + 7'h01;
          if (idx == 7'(N_DET - 1))
          begin
            scan_state <= vdc_pkg::SCAN_IDLE;
            scan_busy <= 1'b0;
          end
        end
        default:
          scan_state <= vdc_pkg::SCAN_IDLE;
      endcase
    end
  end

  assign scan_v = (scan_state == vdc_pkg::SCAN_RUN);

  // ---------------------------------------------------------------
  // Configuration
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < N_DET; i++)
        cfg_mem[i] <= '0;
    end
    else if (cfg_we)
      cfg_mem[cfg_idx] <= cfg_data;
  end

  // ---------------------------------------------------------------
  // Per-detector evaluation
  // ---------------------------------------------------------------
  vdc_pkg::vdc_cfg_t c;
  logic src_pres, pg, sg, has_p, delayed, q_open, green_act, rise;
  logic fail, fail_svc, fail_call, fail_ext;
  logic [11:0] q_lim, tgt;
  logic [17:0] idle_lim, stuck_lim;
  logic [7:0] chat_with, tgt_sec;
  logic [3:0] pix;
  logic [11:0] next_dly, next_q, next_hold;
  logic [7:0] next_ext, next_chat;
  logic [17:0] next_idle, next_stuck;
  logic next_idle_f, next_stuck_f, next_chat_f;
  logic next_call, next_extend, next_sext;

  always_comb
  begin
    c = cfg_mem[idx];
    // R21: own physical input or another logical detector
    src_pres = (c.src_sel == 8'h00) ? det_in[idx]
                                    : pres_q[7'(c.src_sel - 8'h01)];
    pg = phase_on(phase.green, c.call_phase);
    sg = phase_on(phase.green, c.switch_phase);
    has_p = (c.call_phase != 5'h00);
    rise = src_pres && !prev_pres[idx];
    // R1: hold off while not green until delay expires
    delayed = src_pres && (pg || (dly_cnt[idx] >= c.delay_tenths));
    if (pg || !src_pres)
      next_dly = 12'h000;
    else if (dly_cnt[idx] < c.delay_tenths)
      next_dly = dly_cnt[idx] + 12'h001;
    else
      next_dly = dly_cnt[idx];
    // R3: queue window opens at start of green
    q_lim = sec_to_tenths(c.queue_sec);
    q_open = q_cnt[idx] < q_lim;
    if (!pg)
      next_q = 12'h000;
    else if (q_open)
      next_q = q_cnt[idx] + 12'h001;
    else
      next_q = q_cnt[idx];
    // R2: stretch past the end of the actuation
    if (!pg)
      next_ext = 8'h00;
    else if (src_pres)
      next_ext = c.extend_tenths;
    else if (ext_cnt[idx] != 8'h00)
      next_ext = ext_cnt[idx] - 8'h01;
    else
      next_ext = 8'h00;
    // R4: extend overrides queue
    green_act = c.opt_extend ? (src_pres || ext_cnt[idx] != 8'h00)
                             : (c.opt_queue && src_pres && q_open);
    // R20: timeouts scaled from minutes to tenths
    idle_lim = min_to_tenths(c.idle_timeout);
    stuck_lim = min_to_tenths(c.stuck_on_timeout);
    // R10: no call within the idle timeout
    if (src_pres || c.idle_timeout == 8'h00)
      next_idle = 18'h00000;
    else if (idle_cnt[idx] < idle_lim)
      next_idle = idle_cnt[idx] + 18'h00001;
    else
      next_idle = idle_cnt[idx];
    next_idle_f = (c.idle_timeout != 8'h00) && !src_pres &&
                  (idle_f[idx] || next_idle >= idle_lim);
    // R12: call held on past the stuck-on timeout
    if (!src_pres || c.stuck_on_timeout == 8'h00)
      next_stuck = 18'h00000;
    else if (stuck_cnt[idx] < stuck_lim)
      next_stuck = stuck_cnt[idx] + 18'h00001;
    else
      next_stuck = stuck_cnt[idx];
    next_stuck_f = (c.stuck_on_timeout != 8'h00) && src_pres &&
                   (next_stuck >= stuck_lim);
    // R14: actuations per minute against threshold
    chat_with = (rise && chat_cnt[idx] != 8'hff) ? chat_cnt[idx] + 8'h01
                                                 : chat_cnt[idx];
    next_chat = minute_end ? 8'h00 : chat_with;
    if (c.chatter_threshold == 8'h00)
      next_chat_f = 1'b0;
    else if (!minute_end)
      next_chat_f = chat_f[idx];
    else if (chat_with > c.chatter_threshold)
      next_chat_f = 1'b1;
    else if (chat_with < c.chatter_threshold)
      next_chat_f = 1'b0;
    else
      next_chat_f = chat_f[idx];
    fail = next_idle_f || next_stuck_f || next_chat_f;
    // R16: service for the longer of min green and hold time
    pix = 4'(c.call_phase - 5'h01);
    tgt_sec = (min_green[pix] > c.failure_hold_time) ? min_green[pix]
                                                     : c.failure_hold_time;
    // R19: never beyond maximum green
    if (tgt_sec > max_green[pix])
      tgt_sec = max_green[pix];
    tgt = sec_to_tenths(tgt_sec);
    if (pg && fail && hold_cnt[idx] < tgt)
      next_hold = hold_cnt[idx] + 12'h001;
    else if (pg && fail)
      next_hold = hold_cnt[idx];
    else
      next_hold = 12'h000;
    // R17: hold time zero places no recall
    fail_svc = fail && has_p && (c.failure_hold_time != `VDC_HOLD_OFF);
    fail_call = fail_svc && !pg;
    // R18: maximum hold time extends without end
    fail_ext = fail_svc && pg &&
               ((c.failure_hold_time == `VDC_HOLD_CONST) ||
                (hold_cnt[idx] < tgt));
    // R5: red needs call option, green needs extend or queue
    // R8: normal call only while primary and secondary not green; failure recall whenever primary not green
    // R6: phase zero gives neither call nor extend
    next_call = has_p &&
                ((c.opt_call && delayed && !pg && !sg) || fail_call);
    // R9: qualified green actuation restarts extension
    next_extend = has_p && ((pg && green_act) || fail_ext);
    // R7: secondary extended, primary not called
    next_sext = has_p && (c.switch_phase != 5'h00) && sg && !pg &&
                src_pres;
  end

  // ---------------------------------------------------------------
  // Per-detector timers
  // ---------------------------------------------------------------
  // R22: state kept separately for each detector
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < N_DET; i++)
      begin
        dly_cnt[i] <= 12'h000;
        ext_cnt[i] <= 8'h00;
        q_cnt[i] <= 12'h000;
        hold_cnt[i] <= 12'h000;
      end
      prev_pres <= '0;
      pres_q <= '0;
    end
    else if (scan_v)
    begin
      dly_cnt[idx] <= next_dly;
      ext_cnt[idx] <= next_ext;
      q_cnt[idx] <= next_q;
      hold_cnt[idx] <= next_hold;
      prev_pres[idx] <= src_pres;
      pres_q[idx] <= src_pres;
    end
  end

  // Diagnostic counters and flags
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < N_DET; i++)
      begin
        idle_cnt[i] <= 18'h00000;
        stuck_cnt[i] <= 18'h00000;
        chat_cnt[i] <= 8'h00;
      end
      idle_f <= '0;
      stuck_f <= '0;
      chat_f <= '0;
    end
    else if (scan_v)
    begin
      idle_cnt[idx] <= next_idle;
      stuck_cnt[idx] <= next_stuck;
      chat_cnt[idx] <= next_chat;
      idle_f[idx] <= next_idle_f;
      stuck_f[idx] <= next_stuck_f;
      chat_f[idx] <= next_chat_f;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      call_out <= '0;
      ext_out <= '0;
      sec_ext_out <= '0;
      fail_out <= '0;
    end
    else if (scan_v)
    begin
      call_out[idx] <= next_call;
      ext_out[idx] <= next_extend;
      sec_ext_out[idx] <= next_sext;
      fail_out[idx] <= fail;
    end
  end

  // R11: R13: R15: fault code in the occupancy sample
  always_ff @(posedge clk)
  begin
    if (!resetn)
      occ_code <= `VDC_CODE_NONE;
    else if (stuck_f[occ_sel])
      occ_code <= `VDC_CODE_STUCK;
    else if (idle_f[occ_sel])
      occ_code <= `VDC_CODE_IDLE;
    else if (chat_f[occ_sel])
      occ_code <= `VDC_CODE_CHATTER;
    else
      occ_code <= `VDC_CODE_NONE;
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_green_no_call: assert property (scan_v && pg |=> !call_out[last_d]) // R8
    else $error("call placed while primary green");
  a_zero_phase: assert property (scan_v && !has_p |=>
    !call_out[last_d] && !ext_out[last_d]) // R6
    else $error("phase zero drove call or extend");
  a_sec_extend: assert property (scan_v && has_p && sg && !pg &&
    src_pres && c.switch_phase != 5'h00 |=> sec_ext_out[last_d]) // R7
    else $error("secondary not extended");
  a_delay_hold: assert property (scan_v && !pg && !fail &&
    dly_cnt[idx] < c.delay_tenths |=> !call_out[last_d]) // R1
    else $error("call before delay expired");
  a_queue_cut: assert property (scan_v && pg && !fail && !c.opt_extend &&
    !q_open |=> !ext_out[last_d]) // R3
    else $error("actuation passed after queue limit");
  a_hold_off: assert property (scan_v && fail && !src_pres &&
    c.failure_hold_time == 8'h00 && !pg |=> !call_out[last_d]) // R17
    else $error("recall with hold time zero");
  a_stuck_code: assert property (stuck_f[occ_sel] |=>
    occ_code == 8'hd2 || $changed(occ_sel)) // R13
    else $error("stuck code missing");
  a_idle_code: assert property (idle_f[occ_sel] && !stuck_f[occ_sel] |=>
    occ_code == 8'hd3 || $changed(occ_sel)) // R11
    else $error("idle code missing");
  a_scan_span: assert property (tick && !scan_busy |=> scan_busy // R22
    ##127 scan_busy ##1 !scan_busy)
    else $error("scan did not span 128 cycles");

  c_fail_recall: cover property (scan_v && fail_call);
  c_sec_ext: cover property (scan_v && next_sext);
  c_chatter: cover property (scan_v && minute_end && next_chat_f);
endmodule

// >>> sim/vdc_road_model.sv
// Road-side model: detector presence and signal phase states
module vdc_road_model (
  input wire logic clk,              // System clock
  input wire logic resetn,           // Synchronous reset
  input wire logic scan_busy,        // Scan running in the block
  input wire logic [127:0] pres,     // Steady vehicle presence
  input wire logic [127:0] chat,     // Detectors that chatter
  input wire logic [15:0] grn,       // Green phases
  input wire logic [15:0] yel,       // Yellow phases
  output logic [127:0] det_in,       // Presence to the block
  output vdc_pkg::vdc_phase_t phase  // Phase states to the block
);
  timeunit 1ns;
  timeprecision 100ps;

  logic busy_q;
  logic chat_q;

  // ----------------------------------------
  // Chatter source
  // ----------------------------------------
  // Toggle once per scan so every minute carries many actuations
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      busy_q <= 1'b0;
      chat_q <= 1'b0;
    end
    else
    begin
      busy_q <= scan_busy;
      if (busy_q && !scan_busy)
        chat_q <= ~chat_q;
    end
  end

  assign det_in = pres ^ (chat & {128{chat_q}});
  assign phase = {grn, yel};
endmodule

// >>> sim/tb_vehicle_detector_conditioning.sv
// Self-checking bench for the detector conditioning block
`include "vdc_defines.svh"
module tb_vehicle_detector_conditioning;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int TICK = 140;
  logic clk;
  logic resetn;
  logic cfg_we;
  logic [6:0] cfg_idx;
  vdc_pkg::vdc_cfg_t cfg_data;
  vdc_pkg::vdc_phase_t phase;
  vdc_pkg::vdc_sec_arr_t min_green;
  vdc_pkg::vdc_sec_arr_t max_green;
  logic [127:0] det_in, pres, chat;
  logic [127:0] call_out, ext_out, sec_ext_out, fail_out;
  logic [15:0] grn, yel;
  logic [6:0] occ_sel;
  logic [7:0] occ_code;
  logic scan_busy;
  logic [7:0] code [3];
  int num_errors;
  int cmp_count;
  int nscan;
  vdc_pkg::vdc_cfg_t src_cfg;

  vdc_core #(.TICK_CYCLES(TICK)) dut_u (
    .clk(clk), .resetn(resetn), .cfg_we(cfg_we), .cfg_idx(cfg_idx),
    .cfg_data(cfg_data), .phase(phase), .min_green(min_green),
    .max_green(max_green), .det_in(det_in), .occ_sel(occ_sel),
    .call_out(call_out), .ext_out(ext_out), .sec_ext_out(sec_ext_out),
    .fail_out(fail_out), .occ_code(occ_code), .scan_busy(scan_busy));

  vdc_road_model road_u (
    .clk(clk), .resetn(resetn), .scan_busy(scan_busy), .pres(pres),
    .chat(chat), .grn(grn), .yel(yel), .det_in(det_in), .phase(phase));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic results();
    $display("errors=%0d checks=%0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk({7'h0, got}, {7'h0, exp});
  endtask

  // Waits out n whole scans, then settles at a falling edge
  task automatic wait_scan(input int n);
    int k;
    repeat (n)
    begin
      k = 0;
      while (scan_busy !== 1'b1 && k < 2 * TICK)
      begin
        @(posedge clk);
        k++;
      end
      while (scan_busy !== 1'b0 && k < 4 * TICK)
      begin
        @(posedge clk);
        k++;
      end
      if (k >= 4 * TICK)
      begin
        num_errors++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, scan_busy, 1'b0);
        results();
      end
      nscan++;
    end
    @(negedge clk);
  endtask

  task automatic wr(input logic [6:0] i, input vdc_pkg::vdc_cfg_t c);
    @(posedge clk);
    cfg_we <= 1'b1;
    cfg_idx <= i;
    cfg_data <= c;
  endtask

  task automatic drive(input logic [127:0] p, input logic [15:0] g);
    @(posedge clk);
    pres <= p;
    grn <= g;
  endtask

  function automatic vdc_pkg::vdc_cfg_t mk(input logic [4:0] cp,
    input logic [4:0] sp, input logic [11:0] dly, input logic [7:0] ext,
    input logic [7:0] q, input logic [7:0] idle, input logic [7:0] stuck,
    input logic [7:0] cnt, input logic [7:0] hold, input logic [2:0] opt);
    vdc_pkg::vdc_cfg_t c;
    c = '0;
    c.call_phase = cp;
    c.switch_phase = sp;
    c.delay_tenths = dly;
    c.extend_tenths = ext;
    c.queue_sec = q;
    c.idle_timeout = idle;
    c.stuck_on_timeout = stuck;
    c.chatter_threshold = cnt;
    c.failure_hold_time = hold;
    {c.opt_call, c.opt_extend, c.opt_queue} = opt;
    return c;
  endfunction

  // ----------------------------------------
  // Clock and sequence
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial
  begin
    resetn = 1'b0;
    cfg_we = 1'b0;
    cfg_idx = 7'h00;
    cfg_data = '0;
    pres = 128'h800;
    chat = 128'h1000;
    grn = 16'h0002;
    yel = 16'h0000;
    min_green = {16{8'h01}};
    max_green = {16{8'h1e}};
    max_green[3] = 8'h03;
    occ_sel = 7'h00;
    code = '{`VDC_CODE_IDLE, `VDC_CODE_STUCK, `VDC_CODE_CHATTER};
    num_errors = 0;
    cmp_count = 0;
    nscan = 0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    wr(7'h00, mk(5'h1, 5'h0, 12'h3, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 3'h4));
    wr(7'h01, mk(5'h2, 5'h0, 12'h0, 8'h4, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 3'h2));
    wr(7'h02, mk(5'h0, 5'h0, 12'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 3'h6));
    wr(7'h03, mk(5'h1, 5'h2, 12'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 3'h4));
    wr(7'h04, mk(5'h1, 5'h3, 12'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 3'h4));
    wr(7'h05, mk(5'h3, 5'h0, 12'h0, 8'h0, 8'h1, 8'h0, 8'h0, 8'h0, 8'h0, 3'h1));
    wr(7'h06, mk(5'h3, 5'h0, 12'h0, 8'h0, 8'h1, 8'h0, 8'h0, 8'h0, 8'h0, 3'h3));
    wr(7'h0a, mk(5'h4, 5'h0, 12'h0, 8'h0, 8'h0, 8'h1, 8'h0, 8'h0, 8'h2, 3'h4));
    wr(7'h0b, mk(5'h4, 5'h0, 12'h0, 8'h0, 8'h0, 8'h0, 8'h1, 8'h0, 8'h2, 3'h4));
    wr(7'h0c, mk(5'h4, 5'h0, 12'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'ha, 8'h4, 3'h4));
    wr(7'h0d, mk(5'h4, 5'h0, 12'h0, 8'h0, 8'h0, 8'h1, 8'h0, 8'h0, 8'h0, 3'h4));
    wr(7'h0e, mk(5'h2, 5'h0, 12'h0, 8'h0, 8'h0, 8'h1, 8'h0, 8'h0, 8'hff, 3'h4));
    src_cfg = mk(5'h1, 5'h0, 12'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 3'h4);
    src_cfg.src_sel = 8'h0c;
    wr(7'h0f, src_cfg);
    @(posedge clk);
    cfg_we <= 1'b0;
    wait_scan(2);
    drive(128'h81f, 16'h0002);
    wait_scan(1);
    chk1(call_out[0], 1'b0);
    chk1(ext_out[1], 1'b1);
    chk1(call_out[2] | ext_out[2], 1'b0);
    chk1(call_out[3], 1'b0);
    chk1(sec_ext_out[3], 1'b1);
    chk1(call_out[4], 1'b1);
    chk1(call_out[15], 1'b1);
    wait_scan(4);
    chk1(call_out[0], 1'b1);
    drive(128'h81d, 16'h0002);
    wait_scan(1);
    chk1(ext_out[1], 1'b1);
    wait_scan(6);
    chk1(ext_out[1], 1'b0);
    drive(128'h87d, 16'h0006);
    wait_scan(2);
    chk1(ext_out[5], 1'b1);
    chk1(ext_out[6], 1'b1);
    wait_scan(12);
    chk1(ext_out[5], 1'b0);
    chk1(ext_out[6], 1'b1);
    chk1(fail_out[10], 1'b0);
    wait_scan(615 - nscan);
    chk1(fail_out[10], 1'b1);
    chk1(fail_out[11], 1'b1);
    chk1(fail_out[12], 1'b1);
    chk1(call_out[10], 1'b1);
    chk1(fail_out[13], 1'b1);
    chk1(call_out[13], 1'b0);
    chk1(ext_out[14], 1'b1);
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk);
      occ_sel <= 7'h0a + 7'(i);
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk(occ_code, code[i]);
    end
    drive(128'hc7d, 16'h000e);
    wait_scan(2);
    chk1(fail_out[10], 1'b0);
    chk1(ext_out[11], 1'b1);
    chk1(ext_out[12], 1'b1);
    wait_scan(19);
    chk1(ext_out[11], 1'b0);
    chk1(ext_out[12], 1'b1);
    wait_scan(10);
    chk1(ext_out[12], 1'b0);
    results();
  end
endmodule
